// ### dv/rcrb_bank_tb_top.sv
/*
  Self-checking bench of the register bank: table of register
  accesses, then reset, restart, bit-order and wire-mode cases.
  Assumes the host model in rcrb_spi_host.sv and the design package.
*/
`timescale 1ns/1ps
module rcrb_bank_tb_top
  import rcrb_pkg::*;
;
`define CHK(nm, e, g) begin n_compared++; if ((g) !== (e)) begin \
  num_errors++; $display("[FAIL] %s expected %h seen %h", nm, e, g); \
  end end

  typedef struct packed {
    logic [9:0] addr;
    rcrb_byte_t rst;
    rcrb_byte_t wr;
    rcrb_byte_t exp;
  } rcrb_row_t;

  logic       clk, reset_n, selectN, serialClk, dataIn;
  logic       dataOut, dataOutEn, sdoPin, sdoEn, softRestartOut;
  logic       hostBit, hostDrv, sdioWire, sdoWire, saw3, saw4;
  rcrb_byte_t sampleSynthState, linkSynthState, rdv;
  rcrb_byte_t syncInputPolarity, synthBlockEnables, shufflerControl;
  int         num_errors, n_compared, pulses;
  rcrb_byte_t rstVal [2] = '{8'h80, 8'h01};
  rcrb_row_t  rows [27] = '{
    '{10'h1E4, 8'h00, 8'hA5, 8'hA5}, '{10'h1E5, 8'h00, 8'h3C, 8'h3C},
    '{10'h1E6, 8'h00, 8'h11, 8'h11}, '{10'h1E7, 8'h00, 8'h22, 8'h22},
    '{10'h1E8, 8'h00, 8'h44, 8'h44}, '{10'h1E9, 8'h00, 8'h1F, 8'h1F},
    '{10'h1EA, 8'h00, 8'h81, 8'h81}, '{10'h1EB, 8'h1C, 8'hE3, 8'hE3},
    '{10'h1EC, 8'h9B, 8'h64, 8'h64}, '{10'h1ED, 8'h00, 8'h7E, 8'h7E},
    '{10'h2A0, 8'h00, 8'hC3, 8'hC3}, '{10'h2A1, 8'h80, 8'h7F, 8'h7F},
    '{10'h2A2, 8'h00, 8'h07, 8'h07}, '{10'h2A5, 8'h00, 8'h08, 8'h08},
    '{10'h2AA, 8'h37, 8'hC8, 8'hC8}, '{10'h2AB, 8'hC0, 8'h3F, 8'h3F},
    '{10'h2AC, 8'h19, 8'hE6, 8'hE6}, '{10'h2AD, 8'h00, 8'h80, 8'h80},
    '{10'h2B7, 8'hD0, 8'h2F, 8'h2F}, '{10'h2BB, 8'hB9, 8'h46, 8'h46},
    '{10'h2BC, 8'h80, 8'hFF, 8'h80}, '{10'h2DC, 8'h84, 8'hFF, 8'h84},
    '{10'h340, 8'h03, 8'hFC, 8'hFC}, '{10'h342, 8'hF5, 8'h0A, 8'h0A},
    '{10'h343, 8'h00, 8'h5A, 8'h5A}, '{10'h001, 8'h00, 8'hFF, 8'h00},
    '{10'h3FF, 8'h00, 8'hFF, 8'h00}};

  // ********************************************************************
  // wires, design and host
  // ********************************************************************
  assign sdioWire = dataOutEn ? dataOut : (hostDrv ? hostBit : ~hostBit);
  assign sdoWire  = sdoEn ? sdoPin : ~hostBit;
  assign dataIn   = sdioWire;

  rcrb_bank rcrb_bank_inst (
    .clk                    (clk),
    .reset_n                (reset_n),
    .selectN                (selectN),
    .serialClk              (serialClk),
    .dataIn                 (dataIn),
    .dataOut                (dataOut),
    .dataOutEn              (dataOutEn),
    .serial_read_out_pin    (sdoPin),
    .serial_read_out_pin_en (sdoEn),
    .sampleSynthState       (sampleSynthState),
    .linkSynthState         (linkSynthState),
    .softRestartOut         (softRestartOut),
    .syncInputPolarity      (syncInputPolarity),
    .synthBlockEnables      (synthBlockEnables),
    .shufflerControl        (shufflerControl)
  );

  rcrb_spi_host rcrb_spi_host_inst (
    .clk       (clk),
    .sdioWire  (sdioWire),
    .sdoWire   (sdoWire),
    .selectN   (selectN),
    .serialClk (serialClk),
    .hostBit   (hostBit),
    .hostDrv   (hostDrv)
  );

  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  always @(posedge clk) begin
    if (softRestartOut === 1'b1) pulses++;
    if (dataOutEn === 1'b1) saw3 = 1'b1;
    if (sdoEn === 1'b1) saw4 = 1'b1;
  end

  // ********************************************************************
  // access tasks and verdict
  // ********************************************************************
  task automatic wr(input logic [9:0] a, input rcrb_byte_t d,
                    input logic l, input logic f);
    rcrb_spi_host_inst.xfer(1'b0, a, d, l, f, rdv);
  endtask

  task automatic rd(input logic [9:0] a, input logic l, input logic f);
    saw3 = 1'b0;
    saw4 = 1'b0;
    rcrb_spi_host_inst.xfer(1'b1, a, 8'h00, l, f, rdv);
  endtask

  task automatic results();
    $display("compared %0d, errors %0d", n_compared, num_errors);
    if (num_errors == 0 && n_compared > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask

  // hang guard, well beyond the length of the sequence
  initial begin
    repeat (90000) @(posedge clk);
    num_errors++;
    $display("[FAIL] watchdog expected end seen none");
    results();
  end

  // ********************************************************************
  // main sequence
  // ********************************************************************
  initial begin
    num_errors = 0;
    n_compared = 0;
    pulses = 0;
    saw3 = 1'b0;
    saw4 = 1'b0;
    reset_n = 1'b0;
    sampleSynthState = 8'h80;
    linkSynthState = 8'h84;
    repeat (2) @(posedge clk);
    #1 reset_n = 1'b1;
    repeat (2) @(posedge clk);
    #1;
    `CHK("restart out", 1'b0, softRestartOut)
    `CHK("shuffler port", 8'h03, shufflerControl)
    `CHK("polarity port", 8'h00, syncInputPolarity)
    rd(10'h000, 1'b0, 1'b1);
    `CHK("format reset", 8'h18, rdv)
    foreach (rows[r]) begin
      rd(rows[r].addr, 1'b0, 1'b1);
      `CHK("reset value", rows[r].rst, rdv)
      wr(rows[r].addr, rows[r].wr, 1'b0, 1'b1);
      rd(rows[r].addr, 1'b0, 1'b1);
      `CHK("readback", rows[r].exp, rdv)
    end
    `CHK("polarity port", 8'hA5, syncInputPolarity)
    `CHK("enables port", 8'hC3, synthBlockEnables)
    `CHK("shuffler port", 8'hFC, shufflerControl)
    // restart through the top bit and through its mirror copy
    foreach (rstVal[j]) begin
      wr(10'h1E4, 8'h66, 1'b0, 1'b1);
      wr(10'h340, 8'hFC, 1'b0, 1'b1);
      pulses = 0;
      wr(10'h000, rstVal[j], 1'b0, 1'b1);
      `CHK("restart pulses", 1, pulses)
      `CHK("shuffler port", 8'h03, shufflerControl)
      rd(10'h000, 1'b0, 1'b1);
      `CHK("format after restart", 8'h18, rdv)
      rd(10'h1E4, 1'b0, 1'b1);
      `CHK("polarity after restart", 8'h00, rdv)
    end
    wr(10'h000, 8'h08, 1'b0, 1'b1);
    rd(10'h000, 1'b0, 1'b1);
    `CHK("wire mirror", 8'h18, rdv)
    `CHK("four wire pin used", 1'b1, saw4)
    `CHK("three wire pin idle", 1'b0, saw3)
    wr(10'h000, 8'h00, 1'b0, 1'b1);
    rd(10'h000, 1'b0, 1'b0);
    `CHK("three wire read", 8'h00, rdv)
    `CHK("three wire pin used", 1'b1, saw3)
    `CHK("four wire pin idle", 1'b0, saw4)
    wr(10'h000, 8'h02, 1'b0, 1'b0);
    rd(10'h000, 1'b1, 1'b0);
    `CHK("order mirror", 8'h42, rdv)
    wr(10'h1E4, 8'h2C, 1'b1, 1'b0);
    wr(10'h000, 8'h10, 1'b1, 1'b0);
    rd(10'h000, 1'b0, 1'b1);
    `CHK("order cleared", 8'h18, rdv)
    rd(10'h1E4, 1'b0, 1'b1);
    `CHK("lsb first write", 8'h2C, rdv)
    `CHK("polarity port", 8'h2C, syncInputPolarity)
    wr(10'h000, 8'h50, 1'b0, 1'b1);
    rd(10'h000, 1'b1, 1'b1);
    `CHK("lsb four wire", 8'h5A, rdv)
    wr(10'h000, 8'h80, 1'b1, 1'b1);
    rd(10'h000, 1'b0, 1'b1);
    `CHK("lsb restart", 8'h18, rdv)
    // mid-run hardware reset with lsb-first 3-wire mode set
    wr(10'h000, 8'h42, 1'b0, 1'b1);
    reset_n = 1'b0;
    repeat (2) @(posedge clk);
    #1 reset_n = 1'b1;
    `CHK("restart out in reset", 1'b0, softRestartOut)
    repeat (2) @(posedge clk);
    #1;
    rd(10'h000, 1'b0, 1'b1);
    `CHK("format after reset", 8'h18, rdv)
    `CHK("four wire after reset", 1'b1, saw4)
    results();
  end
endmodule

// ### dv/rcrb_spi_host.sv
/*
  Host model of the serial control port: one frame per call, header
  then one data byte, most or least significant bit first.
  Assumes the bench resolves the shared data wire and feeds it back.
*/
`timescale 1ns/1ps
module rcrb_spi_host
  import rcrb_pkg::*;
#(
  parameter int PH = 6
) (
  input  wire logic clk,
  input  wire logic sdioWire,
  input  wire logic sdoWire,
  output      logic selectN,
  output      logic serialClk,
  output      logic hostBit,
  output      logic hostDrv
);
  initial begin
    selectN   = 1'b1;
    serialClk = 1'b0;
    hostBit   = 1'b0;
    hostDrv   = 1'b1;
  end

  task automatic tick(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask

  // ********************************************************************
  // frame: serial clock idles low, data set up in the low phase
  // ********************************************************************
  task automatic xfer(input logic rd, input logic [9:0] addr,
                      input rcrb_byte_t wd, input logic lsb,
                      input logic four, output rcrb_byte_t rdv);
    logic [23:0] frm;
    int          k;
    frm = {rd, 5'h00, addr, wd};
    rdv = 8'h00;
    selectN = 1'b0;
    tick(2);
    for (int i = 0; i < 24; i++) begin
      k = (i < 16) ? (lsb ? i + 8 : 23 - i) : (lsb ? i - 16 : 23 - i);
      // released line shows the inverse of the last bit driven
      if (rd && i >= 16) hostDrv = 1'b0;
      else hostBit = frm[k];
      tick(PH);
      serialClk = 1'b1;
      tick(PH - 1);
      if (rd && i >= 16) rdv[k] = four ? sdoWire : sdioWire;
      tick(1);
      serialClk = 1'b0;
    end
    tick(PH);
    selectN = 1'b1;
    hostDrv = 1'b1;
    tick(3);
  endtask
endmodule

// ### hdl/rcrb_bank.sv
/*
  Receiver control register bank behind a serial control port.
  Frame: R/W bit, 15 address bits, 8 data bits; chip select low frames.
  Assumes sclk-domain pins are sampled synchronously to clk, and the
  status inputs come from synthesizer logic on the same clock.
*/
// Operation
// RULE1 - writing the top format bit starts a software reset, self-clearing
// RULE2 - software reset returns every register to its default value
// RULE3 - bit-order flag makes shifting in and out LSB first
// RULE4 - wire-mode flag sends read data on the dedicated output pin
// RULE5 - format bits 0, 1, 3 mirror bits 7, 6, 4
// RULE6 - format register resets to 0x18: 4-wire, MSB first
// RULE7 - writing either mirror copy updates both; reads show both equal
`timescale 1ns/1ps
module rcrb_bank
  import rcrb_pkg::*;
(
  input  wire logic       clk,
  input  wire logic       reset_n,
  input  wire logic       selectN,
  input  wire logic       serialClk,
  input  wire logic       dataIn,
  output      logic       dataOut,
  output      logic       dataOutEn,
  output      logic       serial_read_out_pin,
  output      logic       serial_read_out_pin_en,
  input  wire rcrb_byte_t sampleSynthState,
  input  wire rcrb_byte_t linkSynthState,
  output      logic       softRestartOut,
  output      rcrb_byte_t syncInputPolarity,
  output      rcrb_byte_t synthBlockEnables,
  output      rcrb_byte_t shufflerControl
);
  // ******************************************************************
  // register storage
  // ******************************************************************
  rcrb_byte_t  regs_reg [`RCRB_N_RW];
  rcrb_byte_t  fmtValue;
  logic        lsbFirst;
  logic        fourWire;
  logic        softRestart;
  logic        fmtWrEn;
  logic        regWrEn;
  rcrb_byte_t  wrData;

  function automatic int regIndex(input logic [`RCRB_ADDR_W-1:0] a);
    case (a)
      `RCRB_A_SYNC_POL: regIndex = 0;
      `RCRB_A_LINK_TEST_GENERATOR: regIndex = 1;
      `RCRB_A_ILAS_LEN: regIndex = 2;
      `RCRB_A_SYNC_SIG: regIndex = 3;
      `RCRB_A_TREF_SEL: regIndex = 4;
      `RCRB_A_MF_OFFSET: regIndex = 5;
      `RCRB_A_TREF_WIN: regIndex = 6;
      `RCRB_A_SER_DRV1: regIndex = 7;
      `RCRB_A_SER_DRV2: regIndex = 8;
      `RCRB_A_SER_EMPH: regIndex = 9;
      `RCRB_A_SYN_EN:   regIndex = 10;
      `RCRB_A_SYN_DIVL: regIndex = 11;
      `RCRB_A_SYN_DIVH: regIndex = 12;
      `RCRB_A_OSC_RCAL: regIndex = 13;
      `RCRB_A_OSC_BIAS: regIndex = 14;
      `RCRB_A_OSC_CAL:  regIndex = 15;
      `RCRB_A_CP_CUR:   regIndex = 16;
      `RCRB_A_CP_CALEN: regIndex = 17;
      `RCRB_A_OSC_VAR:  regIndex = 18;
      `RCRB_A_SYN_RDIV: regIndex = 19;
      `RCRB_A_SHUF_CTL: regIndex = 20;
      `RCRB_A_SHUF_THL: regIndex = 21;
      `RCRB_A_SHUF_THH: regIndex = 22;
      default:          regIndex = -1;
    endcase
  endfunction

  function automatic rcrb_byte_t resetValue(input int i);
    case (i)
      7:       resetValue = `RCRB_R_SER_DRV1;
      8:       resetValue = `RCRB_R_SER_DRV2;
      11:      resetValue = `RCRB_R_SYN_DIVL;
      14:      resetValue = `RCRB_R_OSC_BIAS;
      15:      resetValue = `RCRB_R_OSC_CAL;
      16:      resetValue = `RCRB_R_CP_CUR;
      18:      resetValue = `RCRB_R_OSC_VAR;
      19:      resetValue = `RCRB_R_SYN_RDIV;
      20:      resetValue = `RCRB_R_SHUF_CTL;
      21:      resetValue = `RCRB_R_SHUF_THL;
      22:      resetValue = `RCRB_R_SHUF_THH;
      default: resetValue = `RCRB_R_ZERO;
    endcase
  endfunction

  // ******************************************************************
  // serial shifter
  // ******************************************************************
  rcrb_state_t                state_reg;
  logic                       sclkLast_reg;
  logic [4:0]                 bitCnt_reg;
  logic [15:0]                hdr_reg;
  rcrb_byte_t                 data_reg;
  rcrb_byte_t                 rdShift_reg;
  logic                       isRead_reg;
  logic [`RCRB_ADDR_W-1:0]    addr_reg;
  logic                       rise;
  logic                       fall;
  logic [15:0]                hdrNext;
  rcrb_byte_t                 dataNext;
  rcrb_byte_t                 rdValue;
  int                         rdIdx;

  assign rise = serialClk & ~sclkLast_reg;
  assign fall = ~serialClk & sclkLast_reg;
  // right shift in lsb-first mode lands the header in natural order
  assign hdrNext  = lsbFirst ? {dataIn, hdr_reg[15:1]}
                             : {hdr_reg[14:0], dataIn}; // RULE3
  assign dataNext = lsbFirst ? {dataIn, data_reg[7:1]}
                             : {data_reg[6:0], dataIn}; // RULE3

  // only the low address bits are decoded
  function automatic logic [`RCRB_ADDR_W-1:0] hdrAddr(
    input logic [15:0] h);
    hdrAddr = h[`RCRB_ADDR_W-1:0];
  endfunction

  always_comb begin
    rdIdx = regIndex(hdrAddr(hdrNext));
    rdValue = `RCRB_R_ZERO;
    case (hdrAddr(hdrNext))
      `RCRB_A_FORMAT:   rdValue = fmtValue; // RULE7
      `RCRB_A_SMP_STAT: rdValue = sampleSynthState;
      `RCRB_A_LNK_STAT: rdValue = linkSynthState;
      default: begin
        if (rdIdx >= 0) begin
          rdValue = regs_reg[rdIdx];
        end
      end
    endcase
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      sclkLast_reg <= 1'b0;
    end else begin
      sclkLast_reg <= serialClk;
    end
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      state_reg   <= RCRB_IDLE;
      bitCnt_reg  <= 5'h0;
      hdr_reg     <= 16'h0000;
      data_reg    <= `RCRB_R_ZERO;
      rdShift_reg <= `RCRB_R_ZERO;
      isRead_reg  <= 1'b0;
      addr_reg    <= `RCRB_A_FORMAT;
    end else if (selectN) begin
      state_reg  <= RCRB_IDLE;
      bitCnt_reg <= 5'h0;
    end else begin
      case (state_reg)
        RCRB_IDLE: begin
          state_reg <= RCRB_HDR;
        end
        RCRB_HDR: begin
          if (rise) begin
            hdr_reg    <= hdrNext;
            bitCnt_reg <= bitCnt_reg + 5'h1;
            if (bitCnt_reg == `RCRB_INSTR_BITS - 5'h1) begin
              state_reg   <= RCRB_DATA;
              isRead_reg  <= hdrNext[15];
              addr_reg    <= hdrAddr(hdrNext);
              rdShift_reg <= rdValue;
            end
          end
        end
        RCRB_DATA: begin
          // no streaming: rises past the byte are ignored, and the
          // phase stands until select rises so the read pin stays enabled
          if (rise && bitCnt_reg != `RCRB_FRAME_BITS) begin
            data_reg   <= dataNext;
            bitCnt_reg <= bitCnt_reg + 5'h1;
          end
          if (fall && bitCnt_reg != `RCRB_INSTR_BITS) begin
            rdShift_reg <= lsbFirst ? {1'b0, rdShift_reg[7:1]}
                                    : {rdShift_reg[6:0], 1'b0}; // RULE3
          end
        end
        default: begin
          state_reg <= RCRB_IDLE;
        end
      endcase
    end
  end

  logic wrStrobe;
  assign wrStrobe = !selectN && state_reg == RCRB_DATA && rise &&
                    bitCnt_reg == `RCRB_FRAME_BITS - 5'h1 && !isRead_reg;
  assign wrData   = dataNext;
  assign fmtWrEn  = wrStrobe && addr_reg == `RCRB_A_FORMAT;
  assign regWrEn  = wrStrobe && regIndex(addr_reg) >= 0;

  // ******************************************************************
  // read/write registers
  // ******************************************************************
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      for (int i = 0; i < `RCRB_N_RW; i++) begin
        regs_reg[i] <= resetValue(i);
      end
    end else if (softRestart) begin
      for (int i = 0; i < `RCRB_N_RW; i++) begin
        regs_reg[i] <= resetValue(i); // RULE2
      end
    end else if (regWrEn) begin
      regs_reg[regIndex(addr_reg)] <= wrData;
    end
  end

  rcrb_format_reg u_format (
    .clk         (clk),
    .reset_n     (reset_n),
    .wrEn        (fmtWrEn),
    .wrData      (wrData),
    .fmtValue    (fmtValue),
    .lsbFirst    (lsbFirst),
    .fourWire    (fourWire),
    .softRestart (softRestart)
  );

  // ******************************************************************
  // pin and control outputs
  // ******************************************************************
  logic       rdActive;
  rcrb_byte_t syncPol_reg;
  rcrb_byte_t synEn_reg;
  rcrb_byte_t shufCtl_reg;
  logic       restartOut_reg;
  logic       dOut_reg;
  logic       dOutEn_reg;
  logic       sOut_reg;
  logic       sOutEn_reg;

  assign rdActive = !selectN && state_reg == RCRB_DATA && isRead_reg;

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      dOut_reg   <= 1'b0;
      dOutEn_reg <= 1'b0;
      sOut_reg   <= 1'b0;
      sOutEn_reg <= 1'b0;
    end else begin
      dOut_reg   <= lsbFirst ? rdShift_reg[0] : rdShift_reg[7];
      sOut_reg   <= lsbFirst ? rdShift_reg[0] : rdShift_reg[7];
      dOutEn_reg <= rdActive & ~fourWire; // RULE4
      sOutEn_reg <= rdActive & fourWire;  // RULE4
    end
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      syncPol_reg    <= `RCRB_R_ZERO;
      synEn_reg      <= `RCRB_R_ZERO;
      shufCtl_reg    <= `RCRB_R_SHUF_CTL;
      restartOut_reg <= 1'b0;
    end else begin
      syncPol_reg    <= regs_reg[0];
      synEn_reg      <= regs_reg[10];
      shufCtl_reg    <= regs_reg[20];
      restartOut_reg <= softRestart;
    end
  end

  assign dataOut                = dOut_reg;
  assign dataOutEn              = dOutEn_reg;
  assign serial_read_out_pin    = sOut_reg;
  assign serial_read_out_pin_en = sOutEn_reg;
  assign syncInputPolarity      = syncPol_reg;
  assign synthBlockEnables      = synEn_reg;
  assign shufflerControl        = shufCtl_reg;
  assign softRestartOut         = restartOut_reg;

  // ******************************************************************
  // checks
  // ******************************************************************
  logic allDefault;
  logic lsbFirstWr;

  // write data moves on after the strobe, so its bit is kept for $past
  assign lsbFirstWr = wrData[`RCRB_FMT_LSBF_HI] |
                      wrData[`RCRB_FMT_LSBF_LO];

  // restart check helper: every stored byte at its default value
  always_comb begin
    allDefault = 1'b1;
    for (int i = 0; i < `RCRB_N_RW; i++) begin
      if (regs_reg[i] != resetValue(i)) begin
        allDefault = 1'b0;
      end
    end
  end

  AST_WIRE_EXCLUSIVE: assert property ( // RULE4
    @(posedge clk) disable iff (!reset_n)
    !(dataOutEn && serial_read_out_pin_en))
    else $error("both read pins driven");
  AST_FOUR_WIRE_PIN: assert property ( // RULE4
    @(posedge clk) disable iff (!reset_n)
    rdActive && fourWire |=> serial_read_out_pin_en && !dataOutEn)
    else $error("4-wire read not on out pin");
  AST_THREE_WIRE_PIN: assert property ( // RULE4
    @(posedge clk) disable iff (!reset_n)
    rdActive && !fourWire |=> dataOutEn && !serial_read_out_pin_en)
    else $error("3-wire read not on data pin");
  // the read pin must stay enabled until select rises
  AST_DATA_PHASE_HOLDS: assert property ( // RULE4
    @(posedge clk) disable iff (!reset_n)
    state_reg == RCRB_DATA && !selectN |=> state_reg == RCRB_DATA || selectN)
    else $error("data phase left while selected");
  AST_PINS_RELEASED: assert property ( // RULE4
    @(posedge clk) disable iff (!reset_n)
    selectN |=> !dataOutEn && !serial_read_out_pin_en)
    else $error("read pin driven while deselected");

  // restart lives one cycle; registers and format follow on the next edge
  AST_RESTART_DEFAULTS: assert property ( // RULE2
    @(posedge clk) disable iff (!reset_n)
    softRestart |=> regs_reg[7] == `RCRB_R_SER_DRV1 &&
                    regs_reg[20] == `RCRB_R_SHUF_CTL && fourWire)
    else $error("restart left non-default");
  AST_ALL_DEFAULTS: assert property ( // RULE2
    @(posedge clk) disable iff (!reset_n)
    softRestart |=> allDefault)
    else $error("register not default after restart");
  AST_RESTART_PORT: assert property ( // RULE1
    @(posedge clk) disable iff (!reset_n)
    softRestart |=> softRestartOut && !softRestart)
    else $error("restart pulse not one cycle");
  AST_FORMAT_DEFAULT: assert property ( // RULE6
    @(posedge clk) disable iff (!reset_n)
    softRestart |=> fmtValue == `RCRB_R_FORMAT)
    else $error("format not 0x18 after restart");

  AST_RESTART_FROM_WRITE: assert property ( // RULE1
    @(posedge clk) disable iff (!reset_n)
    fmtWrEn && wrData[`RCRB_FMT_RST_HI] && !softRestart |=> softRestart)
    else $error("restart write ignored");
  AST_LSB_ORDER: assert property ( // RULE3
    @(posedge clk) disable iff (!reset_n)
    fmtWrEn && !softRestart |=> lsbFirst == $past(lsbFirstWr))
    else $error("bit order not taken");
endmodule

// ### hdl/rcrb_consts.svh
/*
  Constants of the receiver control register bank: register addresses,
  reset values, format bit positions and serial frame lengths.
  Assumes inclusion by bare name from the package, compiled ahead of the design files.
*/
`ifndef RCRB_CONSTS_SVH
`define RCRB_CONSTS_SVH

// ********************************************************************
// serial frame
// ********************************************************************
`define RCRB_ADDR_W        10
`define RCRB_DATA_W        8
`define RCRB_INSTR_BITS    5'h10
`define RCRB_FRAME_BITS    5'h18
`define RCRB_ADDR_MSB_POS  4'hD

// ********************************************************************
// format register bits
// ********************************************************************
`define RCRB_FMT_RST_HI    7
`define RCRB_FMT_LSBF_HI   6
`define RCRB_FMT_WIRE_HI   4
`define RCRB_FMT_WIRE_LO   3
`define RCRB_FMT_LSBF_LO   1
`define RCRB_FMT_RST_LO    0

// ********************************************************************
// addresses
// ********************************************************************
`define RCRB_A_FORMAT      10'h000
`define RCRB_A_SYNC_POL    10'h1E4
`define RCRB_A_LINK_TEST_GENERATOR    10'h1E5
`define RCRB_A_ILAS_LEN    10'h1E6
`define RCRB_A_SYNC_SIG    10'h1E7
`define RCRB_A_TREF_SEL    10'h1E8
`define RCRB_A_MF_OFFSET   10'h1E9
`define RCRB_A_TREF_WIN    10'h1EA
`define RCRB_A_SER_DRV1    10'h1EB
`define RCRB_A_SER_DRV2    10'h1EC
`define RCRB_A_SER_EMPH    10'h1ED
`define RCRB_A_SYN_EN      10'h2A0
`define RCRB_A_SYN_DIVL    10'h2A1
`define RCRB_A_SYN_DIVH    10'h2A2
`define RCRB_A_OSC_RCAL    10'h2A5
`define RCRB_A_OSC_BIAS    10'h2AA
`define RCRB_A_OSC_CAL     10'h2AB
`define RCRB_A_CP_CUR      10'h2AC
`define RCRB_A_CP_CALEN    10'h2AD
`define RCRB_A_OSC_VAR     10'h2B7
`define RCRB_A_SYN_RDIV    10'h2BB
`define RCRB_A_SMP_STAT    10'h2BC
`define RCRB_A_LNK_STAT    10'h2DC
`define RCRB_A_SHUF_CTL    10'h340
`define RCRB_A_SHUF_THL    10'h342
`define RCRB_A_SHUF_THH    10'h343

// ********************************************************************
// reset values
// ********************************************************************
`define RCRB_R_FORMAT      8'h18
`define RCRB_R_ZERO        8'h00
`define RCRB_R_SER_DRV1    8'h1C
`define RCRB_R_SER_DRV2    8'h9B
`define RCRB_R_SYN_DIVL    8'h80
`define RCRB_R_OSC_BIAS    8'h37
`define RCRB_R_OSC_CAL     8'hC0
`define RCRB_R_CP_CUR      8'h19
`define RCRB_R_OSC_VAR     8'hD0
`define RCRB_R_SYN_RDIV    8'hB9
`define RCRB_R_SHUF_CTL    8'h03
`define RCRB_R_SHUF_THL    8'hF5
`define RCRB_R_SHUF_THH    8'h00

`define RCRB_N_RW          23

`endif

// ### hdl/rcrb_format_reg.sv
/*
  Serial-port format register with mirrored bit copies and a
  self-clearing software restart pulse.
  Assumes writes arrive as single-cycle strobes on clk.
*/
`timescale 1ns/1ps
module rcrb_format_reg
  import rcrb_pkg::*;
(
  input  wire logic       clk,
  input  wire logic       reset_n,
  input  wire logic       wrEn,
  input  wire rcrb_byte_t wrData,
  output      rcrb_byte_t fmtValue,
  output      logic       lsbFirst,
  output      logic       fourWire,
  output      logic       softRestart
);
  logic lsbFirst_reg;
  logic fourWire_reg;
  logic restart_reg;
  logic lsbFirst_next;
  logic fourWire_next;

  // either copy set selects the feature
  assign lsbFirst_next = wrData[`RCRB_FMT_LSBF_HI] |
                         wrData[`RCRB_FMT_LSBF_LO]; // RULE7
  assign fourWire_next = wrData[`RCRB_FMT_WIRE_HI] |
                         wrData[`RCRB_FMT_WIRE_LO]; // RULE7

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      lsbFirst_reg <= 1'b0; // RULE6
      fourWire_reg <= 1'b1; // RULE6
    end else if (restart_reg) begin
      lsbFirst_reg <= 1'b0; // RULE2
      fourWire_reg <= 1'b1; // RULE2
    end else if (wrEn) begin
      lsbFirst_reg <= lsbFirst_next;
      fourWire_reg <= fourWire_next;
    end
  end

  // restart bit lives one cycle, then clears itself
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      restart_reg <= 1'b0;
    end else begin
      restart_reg <= wrEn & ~restart_reg &
                     (wrData[`RCRB_FMT_RST_HI] |
                      wrData[`RCRB_FMT_RST_LO]); // RULE1
    end
  end

  assign fmtValue = {restart_reg, lsbFirst_reg, 1'b0, fourWire_reg,
                     fourWire_reg, 1'b0, lsbFirst_reg,
                     restart_reg}; // RULE5
  assign lsbFirst    = lsbFirst_reg;
  assign fourWire    = fourWire_reg;
  assign softRestart = restart_reg;

  AST_MIRROR_MATCH: assert property ( // RULE7
    @(posedge clk) disable iff (!reset_n)
    fmtValue[`RCRB_FMT_RST_HI] == fmtValue[`RCRB_FMT_RST_LO] &&
    fmtValue[`RCRB_FMT_LSBF_HI] == fmtValue[`RCRB_FMT_LSBF_LO] &&
    fmtValue[`RCRB_FMT_WIRE_HI] == fmtValue[`RCRB_FMT_WIRE_LO])
    else $error("mirror copies differ");
  AST_RESTART_CLEARS: assert property ( // RULE1
    @(posedge clk) disable iff (!reset_n)
    restart_reg |=> !restart_reg)
    else $error("restart stuck");
endmodule

// ### hdl/rcrb_pkg.sv
/*
  Types of the receiver control register bank.
  Assumes rcrb_consts.svh is on the include path.
*/
package rcrb_pkg;
`include "rcrb_consts.svh"

  // gray sequence idle -> header -> data
  typedef enum logic [1:0] {
    RCRB_IDLE = 2'h0,
    RCRB_HDR  = 2'h1,
    RCRB_DATA = 2'h3
  } rcrb_state_t;

  typedef logic [`RCRB_DATA_W-1:0] rcrb_byte_t;
endpackage
